// [src/pmrs_pkg.sv]
package pmrs_pkg;
  // clock rate and derived cycle counts
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned SETTLE_MS       = 20;
  localparam int unsigned OSC_WAIT_MS     = 26;
  localparam int unsigned PIN_LOW_NS      = 1000;
  localparam int unsigned IDLE_HOLD_NS    = 1000;
  localparam int unsigned CLEAR_LIMIT_US  = 500;
  localparam int unsigned SETTLE_CYC      = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned OSC_WAIT_CYC    = OSC_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned PIN_LOW_CYC     = (PIN_LOW_NS * (CLK_HZ / 1_000_000)
                                             + 999) / 1000;
  localparam int unsigned IDLE_HOLD_CYC   = (IDLE_HOLD_NS
                                             * (CLK_HZ / 1_000_000)
                                             + 999) / 1000;
  localparam int unsigned CLEAR_LIMIT_CYC = CLEAR_LIMIT_US
                                            * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W           = 21;
  // register address ranges
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] CFG_LO_FIRST    = 12'h000;
  localparam logic [11:0] CFG_LO_LAST     = 12'h0FF;
  localparam logic [11:0] RES_FIRST       = 12'h200;
  localparam logic [11:0] RES_LAST        = 12'h3FF;
  localparam logic [11:0] CFG_HI_FIRST    = 12'h400;
  localparam logic [11:0] CFG_HI_LAST     = 12'h5FF;
  localparam logic [11:0] WAVE_FIRST      = 12'h800;
  localparam logic [11:0] WAVE_LAST       = 12'hFFF;
  localparam logic [15:0] RUN_IDLE_VAL    = 16'h0000;
  localparam logic [15:0] RUN_GO_VAL      = 16'h0001;
  localparam int unsigned SYNC_STAGES     = 2;

  typedef enum logic [2:0] {
    PMRS_OFF,
    PMRS_WAIT_GOOD,
    PMRS_SETTLE,
    PMRS_OSC_WAIT,
    PMRS_READY
  } pmrs_state_t;
endpackage

// [src/pmrs_sync.sv]
`timescale 1ns/10ps
module pmrs_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  // data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta_r <= INIT;
      q_out  <= INIT;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule // pmrs_sync

// [src/pmrs_clear.sv]
`timescale 1ns/10ps
module pmrs_clear
  import pmrs_pkg::*;
(
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_b_in,
  // control
  input  wire logic                        start_in,
  input  wire logic [pmrs_pkg::ADDR_W-1:0] first_in,
  input  wire logic [pmrs_pkg::ADDR_W-1:0] last_in,
  // clear strobes toward the register array
  output logic                             busy_out,
  output logic                             wr_out,
  output logic      [pmrs_pkg::ADDR_W-1:0] addr_out
);
  import pmrs_pkg::*;

  // walks one address per cycle; restarts if started again
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      wr_out   <= 1'b0;
      addr_out <= '0;
    end else if (start_in) begin
      busy_out <= 1'b1;
      wr_out   <= 1'b1;
      addr_out <= first_in;
    end else if (busy_out && addr_out != last_in) begin
      addr_out <= addr_out + 12'h001;
    end else begin
      busy_out <= 1'b0;
      wr_out   <= 1'b0;
    end
  end
endmodule // pmrs_clear

// [src/pmrs_top.sv]
// Operation
// R1: idle when both mode pins high, else normal; normal output here follows mode pin 1 low only
// R2: regulators on only normal, reset high, supply good
// R3: all supplies good start 20 ms, then oscillator
// R4: 26 ms after oscillator set flag, irq low
// R5: host configures after flag, then writes run
// R6: power-on restores config ranges to defaults
// R7: run 0 to 1 clears results range
// R8: waveform buffer range never cleared by reset
// R9: idle keeps regulators off, no irq, no spi
// R10: supply drop holds reset, restarts from waiting
// R11: reset pin 1 us or soft reset drops regulators
// R12: idle held 1 us drops regulators
// R13: host prefers idle mode for low power reset
// R14: pins and supply indications synchronised first
// R15: flag and irq held until host acknowledges
`timescale 1ns/10ps
module pmrs_top
  import pmrs_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned OSC_CYCLES    = OSC_WAIT_CYC
) (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_b_in,
  // pins
  input  wire logic                        mode_select_pin_0_in,
  input  wire logic                        mode_select_pin_1_in,
  input  wire logic                        reset_pin_b_in,
  // supply-good comparators
  input  wire logic                        main_supply_good_in,
  input  wire logic                        analog_core_supply_good_in,
  input  wire logic                        digital_core_supply_good_in,
  // host-side register events
  input  wire logic                        soft_reset_bit_in,
  input  wire logic                        flag_ack_in,
  input  wire logic                        run_wr_in,
  input  wire logic [15:0]                 run_data_in,
  // power controls
  output logic                             analog_core_supply_en_out,
  output logic                             digital_core_supply_en_out,
  output logic                             osc_en_out,
  output logic                             spi_avail_out,
  output logic                             chip_in_reset_out,
  // status
  output logic                             reset_complete_flag_out,
  output logic                             interrupt_line_one_b_out,
  output logic                             normal_power_mode_out,
  output logic                             idle_power_mode_out,
  // register array maintenance strobes
  output logic                             restore_out,
  output logic                             clear_wr_out,
  output logic      [pmrs_pkg::ADDR_W-1:0] clear_addr_out,
  output logic                             clear_busy_out
);
  import pmrs_pkg::*;

  // synchroniser width; the reset pin starts at its released level
  localparam int unsigned SYNC_W    = 6;
  localparam logic [5:0]  SYNC_INIT = 6'h08;

  logic [5:0]       raw_w;
  logic [5:0]       syn_w;
  logic             msel0_s, msel1_s, rstpin_s;
  logic             vdd_s, asup_s, dsup_s;
  logic             idle_sel;
  logic             supplies_good;
  logic             all_good;
  logic             pin_reset_hit;
  logic             idle_hit;
  logic             shutdown;
  pmrs_state_t      state_r, state_nxt;
  logic [CNT_W-1:0] tmr_r, tmr_nxt;
  logic [7:0]       pin_low_cnt_r;
  logic [7:0]       idle_cnt_r;
  logic             idle_latched_r;
  logic             pin_latched_r;
  logic [15:0]      run_r;
  logic             run_go;
  logic             restore_pend_r;
  logic             clr_busy;
  logic             clr_wr;
  logic [ADDR_W-1:0] clr_addr;

  assign raw_w = {mode_select_pin_0_in, mode_select_pin_1_in,
                  reset_pin_b_in, main_supply_good_in,
                  analog_core_supply_good_in, digital_core_supply_good_in};

  pmrs_sync #(
    .WIDTH (SYNC_W),
    .INIT  (SYNC_INIT)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (raw_w),
    .q_out    (syn_w)
  ); // [R14]

  assign {msel0_s, msel1_s, rstpin_s, vdd_s, asup_s, dsup_s} = syn_w;

  assign idle_sel      = msel1_s & msel0_s; // [R1]
  assign supplies_good = vdd_s;
  assign all_good      = vdd_s & asup_s & dsup_s;

  // reset-pin low-time and idle dwell counters
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pin_low_cnt_r <= 8'h00;
    end else if (rstpin_s) begin
      pin_low_cnt_r <= 8'h00;
    end else if (pin_low_cnt_r < 8'(PIN_LOW_CYC)) begin
      pin_low_cnt_r <= pin_low_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      idle_cnt_r <= 8'h00;
    end else if (!idle_sel) begin
      idle_cnt_r <= 8'h00;
    end else if (idle_cnt_r < 8'(IDLE_HOLD_CYC)) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end

  assign pin_reset_hit = (pin_low_cnt_r >= 8'(PIN_LOW_CYC)); // [R11]
  assign idle_hit      = (idle_cnt_r >= 8'(IDLE_HOLD_CYC)); // [R12]

  // latched until the pin or mode returns, so the sequence waits
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      idle_latched_r <= 1'b1;
      pin_latched_r  <= 1'b0;
    end else begin
      if (idle_hit) begin
        idle_latched_r <= 1'b1;
      end else if (!idle_sel) begin
        idle_latched_r <= 1'b0;
      end
      if (pin_reset_hit) begin
        pin_latched_r <= 1'b1;
      end else if (rstpin_s) begin
        pin_latched_r <= 1'b0;
      end
    end
  end

  assign shutdown = idle_hit | pin_reset_hit | soft_reset_bit_in; // [R11]

  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r;
    if (shutdown) begin
      state_nxt = PMRS_OFF; // [R11] [R12]
    end else begin
      case (state_r)
        PMRS_OFF: begin
          // regulators only in normal mode with reset pin high
          if (!idle_latched_r && !idle_sel && !pin_latched_r
              && rstpin_s && supplies_good) begin
            state_nxt = PMRS_WAIT_GOOD; // [R2] [R9]
          end
        end
        PMRS_WAIT_GOOD: begin
          if (!supplies_good) begin
            state_nxt = PMRS_OFF;
          end else if (all_good) begin
            state_nxt = PMRS_SETTLE; // [R3]
            tmr_nxt   = '0;
          end
        end
        PMRS_SETTLE, PMRS_OSC_WAIT, PMRS_READY: begin
          if (!all_good) begin
            state_nxt = PMRS_WAIT_GOOD; // [R10]
            tmr_nxt   = '0;
          end else if (state_r == PMRS_SETTLE) begin
            if (tmr_r >= CNT_W'(SETTLE_CYCLES - 1)) begin
              state_nxt = PMRS_OSC_WAIT; // [R3]
              tmr_nxt   = '0;
            end else begin
              tmr_nxt = tmr_r + 1'b1;
            end
          end else if (state_r == PMRS_OSC_WAIT) begin
            if (tmr_r >= CNT_W'(OSC_CYCLES - 1)) begin
              state_nxt = PMRS_READY; // [R4]
              tmr_nxt   = '0;
            end else begin
              tmr_nxt = tmr_r + 1'b1;
            end
          end
        end
        default: begin
          state_nxt = PMRS_OFF;
          tmr_nxt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_r <= PMRS_OFF;
      tmr_r   <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  // power and mode outputs
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      analog_core_supply_en_out  <= 1'b0;
      digital_core_supply_en_out <= 1'b0;
      osc_en_out                 <= 1'b0;
      spi_avail_out              <= 1'b0;
      chip_in_reset_out          <= 1'b1;
      normal_power_mode_out      <= 1'b0;
      idle_power_mode_out        <= 1'b0;
    end else begin
      analog_core_supply_en_out  <= (state_nxt != PMRS_OFF); // [R2] [R9]
      digital_core_supply_en_out <= (state_nxt != PMRS_OFF); // [R2] [R9]
      osc_en_out     <= (state_nxt == PMRS_OSC_WAIT)
                        || (state_nxt == PMRS_READY); // [R3]
      spi_avail_out  <= (state_nxt == PMRS_READY) && !idle_sel; // [R9]
      chip_in_reset_out <= (state_nxt != PMRS_READY); // [R10]
      normal_power_mode_out <= !msel1_s; // [R1]
      idle_power_mode_out   <= idle_sel; // [R1]
    end
  end

  // completion flag: set wins over acknowledge
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      reset_complete_flag_out  <= 1'b0;
      interrupt_line_one_b_out <= 1'b1;
    end else if (state_r == PMRS_OSC_WAIT
                 && state_nxt == PMRS_READY) begin
      reset_complete_flag_out  <= 1'b1; // [R4]
      interrupt_line_one_b_out <= 1'b0; // [R4]
    end else if (flag_ack_in) begin
      reset_complete_flag_out  <= 1'b0; // [R15]
      interrupt_line_one_b_out <= 1'b1; // [R15]
    end
  end

  // run register and its 0 to 1 edge; run is reset with the core
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      run_r <= RUN_IDLE_VAL;
    end else if (state_r != PMRS_READY) begin
      run_r <= RUN_IDLE_VAL;
    end else if (run_wr_in) begin
      run_r <= run_data_in; // [R5]
    end
  end

  assign run_go = (state_r == PMRS_READY) && run_wr_in
                  && run_r == RUN_IDLE_VAL
                  && run_data_in == RUN_GO_VAL; // [R7]

  // one restore pulse each time the core leaves the off state
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      restore_pend_r <= 1'b1;
      restore_out    <= 1'b0;
    end else begin
      restore_out <= 1'b0;
      if (state_r == PMRS_OFF) begin
        restore_pend_r <= 1'b1;
      end else if (restore_pend_r && state_r == PMRS_WAIT_GOOD) begin
        restore_pend_r <= 1'b0;
        restore_out    <= 1'b1; // [R6] [R8]
      end
    end
  end

  pmrs_clear u_clear (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .start_in (run_go),
    .first_in (RES_FIRST),
    .last_in  (RES_LAST),
    .busy_out (clr_busy),
    .wr_out   (clr_wr),
    .addr_out (clr_addr)
  ); // [R7] [R8]

  // walker strobes leave through flops like every other output
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      clear_wr_out   <= 1'b0;
      clear_addr_out <= '0;
      clear_busy_out <= 1'b0;
    end else begin
      clear_wr_out   <= clr_wr;
      clear_addr_out <= clr_addr;
      clear_busy_out <= clr_busy;
    end
  end
endmodule // pmrs_top

// [tb/pmrs_top_sva.sv]
`timescale 1ns/10ps
module pmrs_chk #(
  parameter int unsigned SETTLE_CYCLES = 20,
  parameter int unsigned OSC_CYCLES    = 26
) (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // pins, supplies, acknowledge
  input wire logic        mode_select_pin_0_in,
  input wire logic        mode_select_pin_1_in,
  input wire logic        reset_pin_b_in,
  input wire logic        main_supply_good_in,
  input wire logic        analog_core_supply_good_in,
  input wire logic        digital_core_supply_good_in,
  input wire logic        flag_ack_in,
  // device outputs
  input wire logic        analog_core_supply_en_out,
  input wire logic        digital_core_supply_en_out,
  input wire logic        osc_en_out,
  input wire logic        spi_avail_out,
  input wire logic        reset_complete_flag_out,
  input wire logic        interrupt_line_one_b_out,
  input wire logic        idle_power_mode_out,
  input wire logic        clear_wr_out,
  input wire logic [11:0] clear_addr_out,
  input wire logic        clear_busy_out
);
  logic idle_pins;
  logic all_on;
  int   good_cnt_r;
  int   off_cnt_r;
  assign idle_pins = mode_select_pin_0_in && mode_select_pin_1_in;
  assign all_on = analog_core_supply_en_out && main_supply_good_in
    && analog_core_supply_good_in && digital_core_supply_good_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // cycles with regulators on and every supply good
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !all_on) good_cnt_r <= 0;
    else good_cnt_r <= good_cnt_r + 1;
  end
  // cycles of idle pins or reset pin low
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !(idle_pins || !reset_pin_b_in)) off_cnt_r <= 0;
    else off_cnt_r <= off_cnt_r + 1;
  end
  sequence clr_go_s;
    $rose(clear_busy_out) ##0 clear_wr_out;
  endsequence
  sequence clr_mid_s;
    clear_wr_out && clear_addr_out != 12'h3FF;
  endsequence
  idle_out_a: assert property (
    idle_pins [*5] |-> idle_power_mode_out) else $error("idle not shown");
  hold_off_a: assert property (
    off_cnt_r > 60 |-> !analog_core_supply_en_out) else $error("reg on");
  en_pair_a: assert property (
    analog_core_supply_en_out == digital_core_supply_en_out)
    else $error("regs differ");
  main_off_a: assert property (
    !main_supply_good_in [*5] |-> !analog_core_supply_en_out)
    else $error("reg on without main supply");
  settle_a: assert property (
    $rose(osc_en_out) |-> good_cnt_r >= SETTLE_CYCLES
    && good_cnt_r <= SETTLE_CYCLES + 8) else $error("settle wrong");
  flag_time_a: assert property (
    $rose(reset_complete_flag_out) |-> good_cnt_r >= SETTLE_CYCLES
    + OSC_CYCLES && good_cnt_r <= SETTLE_CYCLES + OSC_CYCLES + 10)
    else $error("flag time wrong");
  irq_flag_a: assert property (
    interrupt_line_one_b_out == !reset_complete_flag_out)
    else $error("irq differs");
  flag_hold_a: assert property (
    $fell(reset_complete_flag_out) |-> $past(flag_ack_in)
    || $past(flag_ack_in, 2)) else $error("flag lost");
  clear_start_a: assert property (
    clr_go_s |-> clear_addr_out == 12'h200) else $error("clear start");
  clear_step_a: assert property (
    clr_mid_s |=> clear_wr_out
    && clear_addr_out == $past(clear_addr_out) + 12'h001)
    else $error("clear step");
  spi_idle_a: assert property (
    idle_power_mode_out && $past(idle_power_mode_out) |-> !spi_avail_out)
    else $error("spi in idle");
endmodule // pmrs_chk

bind pmrs_top pmrs_chk #(
  .SETTLE_CYCLES(SETTLE_CYCLES), .OSC_CYCLES(OSC_CYCLES)) u_chk (.*);

// [tb/pmrs_host.sv]
`timescale 1ns/10ps
module pmrs_host (
  // clock
  input  wire logic       clk_in,
  // device status and bench command
  input  wire logic       irq_b_in,
  input  wire logic       go_in,
  input  wire logic [3:0] lag_in,
  // register events toward the device
  output logic            ack_out,
  output logic            run_wr_out,
  output logic     [15:0] run_data_out
);
  initial begin
    ack_out = 1'h0;
    run_wr_out = 1'h0;
    run_data_out = 16'hFFFE;
  end
  // no traffic until the completion interrupt is seen
  always begin
    @(negedge clk_in);
    if (go_in && !irq_b_in) begin
      repeat (int'(lag_in) + 1) @(negedge clk_in);
      ack_out = 1'h1;
      @(negedge clk_in);
      ack_out = 1'h0;
      run_data_out = 16'h0001;
      run_wr_out = 1'h1;
      @(negedge clk_in);
      run_wr_out = 1'h0;
      // released data shows the inverse of the last word
      run_data_out = 16'hFFFE;
      wait (!go_in);
    end
  end
endmodule // pmrs_host

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
  localparam int SET = 20;
  localparam int OSC = 26;
  logic clk_in, rst_b_in = 1'h0, msel0 = 1'h0, msel1 = 1'h0, rpin_b = 1'h1;
  logic main_g = 1'h0, an_g = 1'h0, dg_g = 1'h0, srst = 1'h0;
  logic go = 1'h0, drop = 1'h0, rst_seen = 1'h0, wave_hit = 1'h0;
  logic an_en, dg_en, osc_en, spi, in_rst, flag, irq_b, normal, idle;
  logic restore, clr_wr, clr_busy, ack, rwr;
  logic [3:0] lag = 4'h0;
  logic [11:0] clr_addr, first_a, last_a;
  logic [15:0] rdata;
  int error_cnt = 0, checks_done = 0, cyc = 0, wr_n = 0;
  pmrs_top #(.SETTLE_CYCLES(SET), .OSC_CYCLES(OSC)) DUT (
    .clk_in(clk_in), .rst_b_in(rst_b_in),
    .mode_select_pin_0_in(msel0), .mode_select_pin_1_in(msel1),
    .reset_pin_b_in(rpin_b), .main_supply_good_in(main_g),
    .analog_core_supply_good_in(an_g), .digital_core_supply_good_in(dg_g),
    .soft_reset_bit_in(srst), .flag_ack_in(ack), .run_wr_in(rwr),
    .run_data_in(rdata), .analog_core_supply_en_out(an_en),
    .digital_core_supply_en_out(dg_en), .osc_en_out(osc_en),
    .spi_avail_out(spi), .chip_in_reset_out(in_rst),
    .reset_complete_flag_out(flag), .interrupt_line_one_b_out(irq_b),
    .normal_power_mode_out(normal), .idle_power_mode_out(idle),
    .restore_out(restore), .clear_wr_out(clr_wr),
    .clear_addr_out(clr_addr), .clear_busy_out(clr_busy));
  pmrs_host u_host (.clk_in(clk_in), .irq_b_in(irq_b), .go_in(go),
    .lag_in(lag), .ack_out(ack), .run_wr_out(rwr), .run_data_out(rdata));
  initial begin
    clk_in = 1'h0;
    forever #10 clk_in = ~clk_in;
  end
  // core supply comparators follow their regulators; drop forces the digital one low
  always @(negedge clk_in) begin
    an_g <= an_en;
    dg_g <= dg_en && !drop;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (restore) rst_seen <= 1'h1;
    if (clr_wr) begin
      if (wr_n == 0) first_a <= clr_addr;
      last_a <= clr_addr;
      wr_n <= wr_n + 1;
      if (clr_addr >= 12'h800) wave_hit <= 1'h1;
    end
    if (cyc == 10000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  function automatic logic pick(int s);
    case (s)
      0: return an_en;
      1: return osc_en;
      2: return flag;
      default: return clr_busy;
    endcase
  endfunction
  task automatic wt(int s, logic v, int lim, string nm);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    chk(nm, 12'(v), 12'(pick(s)));
  endtask
  task automatic power_up;
    repeat (20) @(negedge clk_in);
    chk("en_no_main", 12'h0, 12'(an_en));
    main_g = 1'h1;
    wt(0, 1'h1, 10, "en_on");
    chk("normal", 12'h1, 12'(normal));
    wt(1, 1'h1, SET + 20, "osc_on");
    chk("flag_early", 12'h0, 12'(flag));
    wt(2, 1'h1, OSC + 10, "flag_on");
    chk("irq", 12'h0, 12'(irq_b));
    chk("spi", 12'h1, 12'(spi));
    chk("restore", 12'h1, 12'(rst_seen));
  endtask
  task automatic ack_run(logic [3:0] l);
    repeat (10) @(negedge clk_in);
    chk("flag_held", 12'h1, 12'(flag));
    wr_n = 0;
    wave_hit = 1'h0;
    lag = l;
    go = 1'h1;
    wt(3, 1'h1, 40, "clear_go");
    wt(3, 1'h0, 600, "clear_end");
    go = 1'h0;
    chk("flag_ack", 12'h0, 12'(flag));
    chk("irq_ack", 12'h1, 12'(irq_b));
    chk("clear_cnt", 12'h200, 12'(wr_n));
    chk("clear_first", 12'h200, first_a);
    chk("clear_last", 12'h3FF, last_a);
    chk("wave_kept", 12'h0, 12'(wave_hit));
  endtask
  task automatic brownout;
    drop = 1'h1;
    repeat (6) @(negedge clk_in);
    chk("held_rst", 12'h1, 12'(in_rst));
    chk("spi_drop", 12'h0, 12'(spi));
    drop = 1'h0;
    repeat (SET + OSC - 4) @(negedge clk_in);
    chk("timer_again", 12'h0, 12'(flag));
    wt(2, 1'h1, 30, "flag_again");
    ack_run(4'h9);
  endtask
  task automatic pin_reset;
    rpin_b = 1'h0;
    repeat (20) @(negedge clk_in);
    rpin_b = 1'h1;
    repeat (10) @(negedge clk_in);
    chk("short_pin", 12'h1, 12'(an_en));
    rpin_b = 1'h0;
    repeat (60) @(negedge clk_in);
    chk("pin_off", 12'h0, 12'(dg_en));
    rpin_b = 1'h1;
    wt(0, 1'h1, 10, "pin_on");
    wt(2, 1'h1, SET + OSC + 20, "pin_flag");
    ack_run(4'h3);
  endtask
  task automatic soft_reset;
    srst = 1'h1;
    repeat (8) @(negedge clk_in);
    chk("soft_off", 12'h0, 12'(an_en));
    srst = 1'h0;
    wt(0, 1'h1, 10, "soft_on");
    wt(2, 1'h1, SET + OSC + 20, "soft_flag");
    ack_run(4'h0);
  endtask
  task automatic idle_mode;
    msel0 = 1'h1;
    msel1 = 1'h1;
    repeat (60) @(negedge clk_in);
    chk("idle_off", 12'h0, 12'(an_en));
    chk("idle_out", 12'h1, 12'(idle));
    chk("idle_spi", 12'h0, 12'(spi));
    repeat (SET + OSC + 20) @(negedge clk_in);
    chk("idle_flag", 12'h0, 12'(flag));
    chk("idle_en", 12'h0, 12'(dg_en));
    msel1 = 1'h0;
    wt(0, 1'h1, 10, "idle_back");
    chk("msel0_high_normal", 12'h1, 12'(normal));
    wt(2, 1'h1, SET + OSC + 20, "idle_flag2");
  endtask
  task complete_run;
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_in);
    rst_b_in = 1'h1;
    power_up();
    ack_run(4'h0);
    brownout();
    pin_reset();
    soft_reset();
    idle_mode();
    complete_run();
  end
endmodule // tb
